// file: rtl/rsq_pkg.sv
// Constants, rail map and state encoding for the rail sequencer block.
// Assumes a single 40 MHz reference clock and synchronous control inputs.
package rsq_pkg;

  localparam int CLK_HZ = 40_000_000;

  // Time figures in their own units, with cycle counts derived from them.
  localparam int ONE_MS_CYC     = CLK_HZ / 1000;
  localparam int UV_FALL_MS     = 1;
  localparam int UV_FALL_CYC    = UV_FALL_MS * ONE_MS_CYC;
  localparam int UV_RISE_US     = 10;
  localparam int UV_RISE_CYC    = (UV_RISE_US * (CLK_HZ / 1000)) / 1000;
  localparam int ARM_MS         = 5;
  localparam int WAIT_EN_S      = 20;
  localparam int WAIT_EN_MS     = WAIT_EN_S * 1000;
  localparam int LONG_PRESS_S   = 8;
  localparam int LONG_ALT_S     = 15;
  localparam int LONG_PRESS_MS  = LONG_PRESS_S * 1000;
  localparam int LONG_ALT_MS    = LONG_ALT_S * 1000;
  localparam int PDOWN_MS       = 500;
  localparam int DISCHARGE_MS   = 150;
  localparam int DLY_BASE_MS    = 2;
  localparam int DLY_MAX_MS     = 5;
  localparam int DLY_SCALE      = 10;

  // Sequencer shape.
  localparam int NUM_STROBES    = 10;
  localparam int NUM_DELAYS     = 9;
  localparam int STROBE_W       = 4;
  localparam int DELAY_W        = 2;
  localparam int NUM_RAILS      = 10;
  localparam int NUM_SEQ_RAILS  = 8;
  localparam int NUM_MON        = 5;

  // Rail positions in the enable vector.
  localparam int RAIL_BUCK_A    = 0;
  localparam int RAIL_BUCK_B    = 1;
  localparam int RAIL_BUCK_C    = 2;
  localparam int RAIL_BUCK_BOOST = 3;
  localparam int RAIL_BACKUP_LO = 4;
  localparam int RAIL_BACKUP_HI = 5;
  localparam int RAIL_LINEAR    = 6;
  localparam int RAIL_LV_SWITCH = 7;
  localparam int RAIL_5V_SWITCH = 8;
  localparam int RAIL_HV_SWITCH = 9;

  localparam int MON_RAIL [NUM_MON] = '{RAIL_BUCK_A, RAIL_BUCK_B,
                                        RAIL_BUCK_C, RAIL_BUCK_BOOST,
                                        RAIL_LINEAR};

  // Reset values.
  localparam logic [9:0] RAIL_EN_RST  = 10'h000;
  localparam logic [9:0] DISCHG_RST   = 10'h000;

  typedef enum logic [2:0] {
    RSQ_OFF      = 3'h0,
    RSQ_WAIT     = 3'h1,
    RSQ_ACTIVE   = 3'h3,
    RSQ_PDOWN    = 3'h2,
    RSQ_SUSPEND  = 3'h6,
    RSQ_RECOVERY = 3'h7,
    RSQ_STANDBY  = 3'h4
  } rsq_state_t;

endpackage

// file: rtl/rsq_rail_monitor.sv
// Undervoltage supervisor for one monitored rail.
// Assumes the comparator output is synchronous and ms_tick is a 1 ms pulse.
`timescale 1ns/100ps
module rsq_rail_monitor #(
  parameter int FALL_CYC = rsq_pkg::UV_FALL_CYC,
  parameter int RISE_CYC = rsq_pkg::UV_RISE_CYC
) (
  input  wire logic ref_clk,     // Reference clock.
  input  wire logic sys_rst,     // Synchronous reset, active high.
  input  wire logic ms_tick,     // One-cycle pulse each millisecond.
  input  wire logic rail_on,     // Rail enable bit.
  input  wire logic below_thr,   // Rail below 90 percent of target.
  output logic      fault        // Deglitched undervoltage on armed rail.
);

  logic [2:0]  arm_ms;
  logic        armed;
  logic [15:0] glitch_cnt;

  // A rail is given time to ramp before it is judged.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !rail_on) begin
      arm_ms <= 3'h0;
      armed  <= 1'b0;
    end else if (!armed && ms_tick) begin
      arm_ms <= arm_ms + 3'h1;
      armed  <= (arm_ms == 3'(rsq_pkg::ARM_MS - 1));
    end
  end

  // Only an enabled, armed rail can raise a fault.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !armed) begin
      fault      <= 1'b0;
      glitch_cnt <= 16'h0000;
    end else if (below_thr != fault) begin
      if (glitch_cnt == 16'(fault ? RISE_CYC - 1 : FALL_CYC - 1)) begin
        fault      <= below_thr;
        glitch_cnt <= 16'h0000;
      end else begin
        glitch_cnt <= glitch_cnt + 16'h0001;
      end
    end else begin
      glitch_cnt <= 16'h0000;
    end
  end

endmodule

// file: rtl/rsq_sequencer.sv
// Power-state machine, ten-strobe rail sequencer and power-good control.
// Assumes all inputs are synchronous to ref_clk and the pin is open drain.
`timescale 1ns/100ps
module rsq_sequencer #(
  parameter int MS_CYCLES      = rsq_pkg::ONE_MS_CYC,
  parameter int UV_FALL_CYCLES = rsq_pkg::UV_FALL_CYC
) (
  input  wire logic        ref_clk,              // Reference clock.
  input  wire logic        sys_rst,              // Synchronous reset.
  input  wire logic        power_button_input,   // Button, low when pressed.
  input  wire logic        adapter_detect_input, // Adapter detect, low active.
  input  wire logic        power_enable_input,   // Host enable, high on.
  input  wire logic        main_supply_present,  // Main supply arrived.
  input  wire logic        supply_lockout,       // Undervoltage lockout.
  input  wire logic        thermal_shutdown,     // Overtemperature shutdown.
  input  wire logic        long_press_select,    // 1: 15 s long press.
  input  wire logic        suspend_select,       // 1: enable low to suspend.
  input  wire logic        powerdown_delay_scale, // 1: power-down gaps x10.
  input  wire logic [31:0] strobe_assignment,    // 4 bits per rail 0..7.
  input  wire logic [17:0] strobe_delay,         // 2 bits per gap, 2..5 ms.
  input  wire logic [7:0]  good_release_delay,   // Good delay in ms.
  input  wire logic        enable_write,         // Software enable write.
  input  wire logic [9:0]  enable_write_data,    // Enable value written.
  input  wire logic [4:0]  rail_below_threshold, // Monitored rails low.
  output logic [9:0]       rail_enable_register, // Live rail enables.
  output logic [9:0]       rail_discharge,       // Discharge path on.
  output logic             rails_good_output_out, // Pin level when driven.
  output logic             rails_good_output_oe, // Pulls the pin low.
  output logic [2:0]       power_state           // Present power state.
);

  rsq_pkg::rsq_state_t state;
  rsq_pkg::rsq_state_t dest;
  rsq_pkg::rsq_state_t next_dest;

  logic        prev_pb;
  logic        prev_ac;
  logic        prev_en;
  logic        prev_sup;
  logic [15:0] ms_cnt;
  logic        ms_tick;
  logic [14:0] wait_ms;
  logic [14:0] press_ms;
  logic [8:0]  pd_ms;
  logic [7:0]  hold_ms;
  logic [7:0]  good_ms;
  logic        seq_up;
  logic        seq_dn;
  logic        seq_first;
  logic        up_done;
  logic [3:0]  strobe_idx;
  logic [5:0]  gap_cnt;
  logic        fire_up;
  logic        fire_dn;
  logic        up_start;
  logic        pd_start;
  logic        final_entry;
  logic        wake;
  logic        clear_ok;
  logic        long_press;
  logic        fault_any;
  logic        sw_ok;
  logic        mon_any_on;
  logic        pg_ok;
  logic [4:0]  mon_fault;
  logic [4:0]  mon_en;
  logic [9:0]  on_evt;
  logic [9:0]  off_evt;

  // Effective strobe of a rail; strobes one and two belong to the backups.
  function automatic logic [3:0] eff_strobe(input logic [31:0] asg,
                                            input int          r);
    logic [3:0] s;
    s = 4'h0;
    if (r < rsq_pkg::NUM_SEQ_RAILS) begin
      s = asg[r*rsq_pkg::STROBE_W +: rsq_pkg::STROBE_W];
    end
    if (s > 4'(rsq_pkg::NUM_STROBES)) begin
      s = 4'h0;
    end
    if (s < 4'h3 && r != rsq_pkg::RAIL_BACKUP_LO &&
        r != rsq_pkg::RAIL_BACKUP_HI) begin
      s = 4'h0;
    end
    return s;
  endfunction

  // Gap in ms after strobe k, field value 0..3 giving 2..5 ms.
  function automatic logic [5:0] gap_ms(input logic [17:0] d,
                                        input logic [3:0]  k);
    logic [1:0] f;
    f = d[(k - 4'h1)*rsq_pkg::DELAY_W +: rsq_pkg::DELAY_W];
    return 6'(rsq_pkg::DLY_BASE_MS) + {4'h0, f};
  endfunction

  function automatic logic is_backup(input int r);
    return (r == rsq_pkg::RAIL_BACKUP_LO) || (r == rsq_pkg::RAIL_BACKUP_HI);
  endfunction

  assign power_state = state;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_pb  <= 1'b1;
      prev_ac  <= 1'b1;
      prev_en  <= 1'b0;
      prev_sup <= 1'b1;
    end else begin
      prev_pb  <= power_button_input;
      prev_ac  <= adapter_detect_input;
      prev_en  <= power_enable_input;
      prev_sup <= main_supply_present;
    end
  end

  // The prescaler restarts with each sequence so gaps and 500 ms are exact.
  assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (sys_rst || up_start || pd_start || ms_tick) begin
      ms_cnt <= 16'h0000;
    end else begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  // Wake and power-down decisions.
  assign clear_ok  = ~supply_lockout & ~thermal_shutdown &
                     (hold_ms >= 8'(rsq_pkg::DISCHARGE_MS));
  assign fault_any = |mon_fault;
  assign long_press = long_press_select ?
                      (press_ms >= 15'(rsq_pkg::LONG_ALT_MS)) :
                      (press_ms >= 15'(rsq_pkg::LONG_PRESS_MS));

  always_comb begin
    wake = 1'b0;
    case (state)
      rsq_pkg::RSQ_OFF:
        wake = (prev_pb & ~power_button_input) |
               (prev_ac & ~adapter_detect_input) |
               (~prev_en & power_enable_input) |
               (~prev_sup & main_supply_present &
                ~adapter_detect_input);
      rsq_pkg::RSQ_STANDBY,
      rsq_pkg::RSQ_SUSPEND:
        wake = (prev_pb & ~power_button_input) |
               (prev_ac & ~adapter_detect_input) |
               power_enable_input;
      rsq_pkg::RSQ_RECOVERY:
        wake = 1'b1;
      default:
        wake = 1'b0;
    endcase
  end

  assign up_start = wake & clear_ok & ~pd_start;

  always_comb begin
    pd_start  = 1'b0;
    next_dest = rsq_pkg::RSQ_OFF;
    if (state == rsq_pkg::RSQ_WAIT || state == rsq_pkg::RSQ_ACTIVE ||
        state == rsq_pkg::RSQ_SUSPEND) begin
      if (supply_lockout || thermal_shutdown || fault_any) begin
        pd_start  = 1'b1;
        next_dest = rsq_pkg::RSQ_RECOVERY;
      end else if (long_press) begin
        pd_start  = 1'b1;
        next_dest = rsq_pkg::RSQ_OFF;
      end else if (state == rsq_pkg::RSQ_WAIT && power_button_input &&
                   adapter_detect_input && !power_enable_input &&
                   wait_ms >= 15'(rsq_pkg::WAIT_EN_MS)) begin
        pd_start  = 1'b1;
        next_dest = rsq_pkg::RSQ_OFF;
      end else if (state == rsq_pkg::RSQ_ACTIVE && !power_enable_input) begin
        pd_start  = 1'b1;
        next_dest = suspend_select ? rsq_pkg::RSQ_SUSPEND :
                                     rsq_pkg::RSQ_STANDBY;
      end
    end
  end

  assign final_entry = (state == rsq_pkg::RSQ_PDOWN) && ms_tick &&
                       (pd_ms == 9'(rsq_pkg::PDOWN_MS - 1));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= rsq_pkg::RSQ_OFF;
      dest  <= rsq_pkg::RSQ_OFF;
    end else begin
      case (state)
        rsq_pkg::RSQ_WAIT: begin
          if (pd_start) begin
            state <= rsq_pkg::RSQ_PDOWN;
            dest  <= next_dest;
          end else if (power_enable_input) begin
            state <= rsq_pkg::RSQ_ACTIVE;
          end
        end
        rsq_pkg::RSQ_ACTIVE,
        rsq_pkg::RSQ_SUSPEND: begin
          if (pd_start) begin
            state <= rsq_pkg::RSQ_PDOWN;
            dest  <= next_dest;
          end else if (up_start) begin
            state <= rsq_pkg::RSQ_WAIT;
          end
        end
        rsq_pkg::RSQ_PDOWN: begin
          if (final_entry) begin
            state <= dest;
          end
        end
        default: begin
          if (up_start) begin
            state <= rsq_pkg::RSQ_WAIT;
          end
        end
      endcase
    end
  end

  // Millisecond timers.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state != rsq_pkg::RSQ_WAIT) begin
      wait_ms <= 15'h0000;
    end else if (ms_tick && wait_ms != 15'h7fff) begin
      wait_ms <= wait_ms + 15'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || power_button_input) begin
      press_ms <= 15'h0000;
    end else if (ms_tick && press_ms != 15'h7fff) begin
      press_ms <= press_ms + 15'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || state != rsq_pkg::RSQ_PDOWN) begin
      pd_ms <= 9'h000;
    end else if (ms_tick) begin
      pd_ms <= pd_ms + 9'h001;
    end
  end

  // Discharge hold: no new power-up until discharge has had its minimum.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_ms <= 8'(rsq_pkg::DISCHARGE_MS);
    end else if (pd_start) begin
      hold_ms <= 8'h00;
    end else if (ms_tick && hold_ms < 8'(rsq_pkg::DISCHARGE_MS)) begin
      hold_ms <= hold_ms + 8'h01;
    end
  end

  // Strobe engine, shared by power-up and power-down.
  assign fire_up = seq_up & (seq_first | (ms_tick & (gap_cnt == 6'h01)));
  assign fire_dn = seq_dn & (seq_first | (ms_tick & (gap_cnt == 6'h01)));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_up     <= 1'b0;
      seq_dn     <= 1'b0;
      seq_first  <= 1'b0;
      up_done    <= 1'b0;
      strobe_idx <= 4'h0;
      gap_cnt    <= 6'h00;
    end else if (pd_start) begin
      seq_up     <= 1'b0;
      seq_dn     <= 1'b1;
      seq_first  <= 1'b1;
      up_done    <= 1'b0;
      strobe_idx <= 4'(rsq_pkg::NUM_STROBES);
    end else if (up_start) begin
      seq_up     <= 1'b1;
      seq_dn     <= 1'b0;
      seq_first  <= 1'b1;
      up_done    <= 1'b0;
      strobe_idx <= 4'h1;
    end else if (fire_up) begin
      seq_first <= 1'b0;
      if (strobe_idx == 4'(rsq_pkg::NUM_STROBES)) begin
        seq_up  <= 1'b0;
        up_done <= 1'b1;
      end else begin
        strobe_idx <= strobe_idx + 4'h1;
        gap_cnt    <= gap_ms(strobe_delay, strobe_idx);
      end
    end else if (fire_dn) begin
      seq_first <= 1'b0;
      if (strobe_idx == 4'h1) begin
        seq_dn <= 1'b0;
      end else begin
        strobe_idx <= strobe_idx - 4'h1;
        gap_cnt    <= powerdown_delay_scale ?
                      6'(gap_ms(strobe_delay, strobe_idx - 4'h1) *
                         6'(rsq_pkg::DLY_SCALE)) :
                      gap_ms(strobe_delay, strobe_idx - 4'h1);
      end
    end else if (ms_tick && gap_cnt != 6'h00 && (seq_up || seq_dn)) begin
      gap_cnt <= gap_cnt - 6'h01;
    end
  end

  // Rail switching events; later conditions take precedence.
  assign sw_ok = enable_write & ~seq_up & ~seq_dn;

  always_comb begin
    on_evt  = 10'h000;
    off_evt = 10'h000;
    for (int i = 0; i < rsq_pkg::NUM_RAILS; i++) begin
      if (sw_ok && (!is_backup(i) || state == rsq_pkg::RSQ_OFF)) begin
        on_evt[i]  = enable_write_data[i];
        off_evt[i] = ~enable_write_data[i];
      end
      if (fire_up && eff_strobe(strobe_assignment, i) == strobe_idx &&
          eff_strobe(strobe_assignment, i) != 4'h0) begin
        on_evt[i]  = 1'b1;
        off_evt[i] = 1'b0;
      end
      if (fire_dn && !is_backup(i) &&
          eff_strobe(strobe_assignment, i) == strobe_idx &&
          eff_strobe(strobe_assignment, i) != 4'h0) begin
        on_evt[i]  = 1'b0;
        off_evt[i] = 1'b1;
      end
      if (pd_start && next_dest != rsq_pkg::RSQ_SUSPEND &&
          i < rsq_pkg::NUM_SEQ_RAILS && !is_backup(i) &&
          eff_strobe(strobe_assignment, i) == 4'h0) begin
        on_evt[i]  = 1'b0;
        off_evt[i] = 1'b1;
      end
      if (final_entry && dest != rsq_pkg::RSQ_SUSPEND &&
          i >= rsq_pkg::NUM_SEQ_RAILS) begin
        on_evt[i]  = 1'b0;
        off_evt[i] = 1'b1;
      end
      if (is_backup(i) && final_entry && dest == rsq_pkg::RSQ_OFF) begin
        on_evt[i]  = 1'b0;
        off_evt[i] = 1'b1;
      end
      if (is_backup(i) && up_start && state == rsq_pkg::RSQ_OFF) begin
        on_evt[i]  = 1'b1;
        off_evt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rail_enable_register <= rsq_pkg::RAIL_EN_RST;
    end else begin
      rail_enable_register <= (rail_enable_register | on_evt) &
                              ~off_evt;
    end
  end

  // A rail switched off discharges until it is enabled again.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rail_discharge <= rsq_pkg::DISCHG_RST;
    end else begin
      rail_discharge <= (rail_discharge | off_evt) & ~on_evt;
    end
  end

  // Supervisor channels for the five monitored rails.
  generate
    for (genvar m = 0; m < rsq_pkg::NUM_MON; m++) begin : g_mon
      assign mon_en[m] = rail_enable_register[rsq_pkg::MON_RAIL[m]];
      rsq_rail_monitor #(
        .FALL_CYC (UV_FALL_CYCLES),
        .RISE_CYC (rsq_pkg::UV_RISE_CYC)
      ) u_mon (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .ms_tick   (ms_tick),
        .rail_on   (mon_en[m]),
        .below_thr (rail_below_threshold[m]),
        .fault     (mon_fault[m])
      );
    end
  endgenerate

  // Power-good release timing.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !up_done) begin
      good_ms <= 8'h00;
    end else if (ms_tick && good_ms != 8'hff) begin
      good_ms <= good_ms + 8'h01;
    end
  end

  assign mon_any_on = |mon_en;
  assign pg_ok = up_done && (good_ms >= good_release_delay) &&
                 !fault_any &&
                 mon_any_on &&
                 !pd_start &&
                 (state == rsq_pkg::RSQ_WAIT ||
                  state == rsq_pkg::RSQ_ACTIVE);

  // The pin is only ever pulled low; high comes from the external pull-up.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rails_good_output_oe  <= 1'b1;
      rails_good_output_out <= 1'b0;
    end else begin
      rails_good_output_oe  <= ~pg_ok;
      rails_good_output_out <= 1'b0;
    end
  end

endmodule

// file: testbench/rsq_host_model.sv
// Host processor model: pulled-up reset pin and the host enable line.
// Assumes the bench decides when the host asks for power.
`timescale 1ns/100ps
module rsq_host_model (
  input  wire logic rails_good_output_oe,  // Device pulls pin low.
  input  wire logic rails_good_output_out, // Level when pulled.
  input  wire logic host_req,              // Host wants power.
  output logic      power_enable_input,    // Enable to device.
  output logic      host_in_reset          // Host held in reset.
);
  // The pin has a pull-up, so it reads high whenever nobody drives it.
  assign host_in_reset = rails_good_output_oe ? !rails_good_output_out
                                              : 1'b0;
  assign power_enable_input = host_req;
endmodule

// file: testbench/rsq_sequencer_props.sv
// Port checker for the rail sequencer, bound into rsq_sequencer.
// Assumes MS_CYCLES matches the bound instance.
`timescale 1ns/100ps
module rsq_sequencer_props #(
  parameter int MS_CYCLES = 20
) (
  input wire logic       ref_clk,               // Clock.
  input wire logic       sys_rst,               // Reset.
  input wire logic       power_button_input,    // Button.
  input wire logic       power_enable_input,    // Host enable.
  input wire logic       supply_lockout,        // Lockout.
  input wire logic       thermal_shutdown,      // Overheat.
  input wire logic [9:0] rail_enable_register,  // Enables.
  input wire logic       rails_good_output_out, // Pin level.
  input wire logic       rails_good_output_oe,  // Pin pull.
  input wire logic [2:0] power_state            // State.
);
  int   pd_cnt;
  logic calm;
  assign calm = !supply_lockout && !thermal_shutdown;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence woke_s;
    power_state == 3'h1 ##0 rail_enable_register[5:4] == 2'b11;
  endsequence
  // Counts samples spent in power-down so the exit can be timed.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || power_state != 3'h2)
      pd_cnt <= 0;
    else
      pd_cnt <= pd_cnt + 1;
  end
  rst_state_a: assert property (disable iff (1'b0) sys_rst |=>
    power_state == 3'h0 && rails_good_output_oe &&
    rail_enable_register == 10'h000) else $error("reset values wrong");
  out_low_a: assert property (rails_good_output_out == 1'b0)
    else $error("pin driven high");
  wake_wait_a: assert property (power_state == 3'h0 && calm &&
    $fell(power_button_input) |=> woke_s) else $error("no wake");
  lock_hold_a: assert property (power_state == 3'h0 && !calm |=>
    power_state == 3'h0) else $error("woke in fault");
  wait_act_a: assert property (power_state == 3'h1 && calm &&
    power_enable_input |=> power_state == 3'h3) else $error("no active");
  act_down_a: assert property (power_state == 3'h3 && calm &&
    !power_enable_input |=> power_state == 3'h2) else $error("no pdown");
  pd_len_a: assert property (power_state != 3'h2 && pd_cnt != 0 |->
    pd_cnt == 500 * MS_CYCLES) else $error("pdown length wrong");
  bkp_on_a: assert property (power_state != 3'h0 |->
    rail_enable_register[5:4] == 2'b11) else $error("backup off");
  idle_low_a: assert property (power_state != 3'h1 &&
    power_state != 3'h3 |-> rails_good_output_oe) else $error("good idle");
endmodule
bind rsq_sequencer rsq_sequencer_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .ref_clk, .sys_rst, .power_button_input, .power_enable_input,
  .supply_lockout, .thermal_shutdown, .rail_enable_register,
  .rails_good_output_out, .rails_good_output_oe, .power_state);

// file: testbench/rsq_sequencer_tb_top.sv
// Self-checking bench for the rail sequencer with a host model beside it.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, a); end end
module rsq_sequencer_tb_top;
  localparam int MSC = 20;
  logic ref_clk = 1'b0, sys_rst = 1'b1, power_button_input = 1'b1;
  logic adapter_detect_input = 1'b1, main_supply_present = 1'b1;
  logic supply_lockout = 1'b0, thermal_shutdown = 1'b0, host_req = 1'b0;
  logic long_press_select = 1'b0, suspend_select = 1'b0;
  logic powerdown_delay_scale = 1'b0, enable_write = 1'b0;
  logic [31:0] strobe_assignment = 32'hA021_0003;
  logic [17:0] strobe_delay = 18'h0_0000;
  logic [7:0] good_release_delay = 8'h00;
  logic [9:0] enable_write_data = 10'h000, rail_enable_register;
  logic [9:0] rail_discharge;
  logic [4:0] rail_below_threshold = 5'h00;
  logic [2:0] power_state;
  logic power_enable_input, rails_good_output_out, rails_good_output_oe;
  logic host_in_reset;
  int n_fail = 0, cmp_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  rsq_sequencer #(.MS_CYCLES(MSC), .UV_FALL_CYCLES(MSC)) dut (
    .ref_clk, .sys_rst, .power_button_input, .adapter_detect_input,
    .power_enable_input, .main_supply_present, .supply_lockout,
    .thermal_shutdown, .long_press_select, .suspend_select,
    .powerdown_delay_scale, .strobe_assignment, .strobe_delay,
    .good_release_delay, .enable_write, .enable_write_data,
    .rail_below_threshold, .rail_enable_register, .rail_discharge,
    .rails_good_output_out, .rails_good_output_oe, .power_state);
  rsq_host_model host (.rails_good_output_oe, .rails_good_output_out,
    .host_req, .power_enable_input, .host_in_reset);
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Polls state and pin pull together; a spent bound ends the run.
  task automatic wait_sg(input logic [2:0] s, input logic g, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ({power_state, rails_good_output_oe} === {s, g})
        return;
      @(posedge ref_clk);
    end
    `CHK("state_wait", {s, g}, {power_state, rails_good_output_oe})
    print_verdict();
  endtask
  task automatic sw_write(input logic [9:0] v);
    enable_write <= 1'b1;
    enable_write_data <= v;
    cyc(1);
    enable_write <= 1'b0;
  endtask
  initial begin
    cyc(16);
    sys_rst <= 1'b0;
    good_release_delay <= 8'h02;
    cyc(2);
    `CHK("reset_pull", 4'h1, {power_state, rails_good_output_oe})
    supply_lockout <= 1'b1;
    power_button_input <= 1'b0;
    cyc(4);
    `CHK("locked", 3'h0, power_state)
    supply_lockout <= 1'b0;
    power_button_input <= 1'b1;
    cyc(2);
    power_button_input <= 1'b0;
    cyc(2);
    `CHK("wake", 5'h07, {power_state, rail_enable_register[5:4]})
    sw_write(10'h002);
    power_button_input <= 1'b1;
    cyc(75);
    `CHK("strobe3_early", 1'b0, rail_enable_register[0])
    cyc(10);
    `CHK("strobe3_late", 1'b1, rail_enable_register[0])
    cyc(320);
    `CHK("rails_up", 10'h0B1, rail_enable_register)
    sw_write(10'h0B3);
    cyc(2);
    `CHK("sw_write", 10'h0B3, rail_enable_register)
    host_req <= 1'b1;
    cyc(2);
    `CHK("active", 3'h3, power_state)
    wait_sg(3'h3, 1'b0, 400);
    `CHK("host_out", 1'b0, host_in_reset)
    suspend_select <= 1'b1;
    host_req <= 1'b0;
    cyc(2);
    `CHK("pdown", 4'h5, {power_state, rails_good_output_oe})
    cyc(1);
    `CHK("s10", 2'b01, {rail_enable_register[7], rail_discharge[7]})
    wait_sg(3'h6, 1'b1, 11000);
    `CHK("kept", 1'b1, rail_enable_register[1])
    host_req <= 1'b1;
    cyc(2);
    `CHK("resume", 3'h1, power_state)
    wait_sg(3'h3, 1'b1, 10);
    powerdown_delay_scale <= 1'b1;
    cyc(400);
    `CHK("rails_again", 10'h0B3, rail_enable_register)
    thermal_shutdown <= 1'b1;
    cyc(3);
    `CHK("fault_down", 3'h2, power_state)
    `CHK("unseq_off", 1'b0, rail_enable_register[1])
    thermal_shutdown <= 1'b0;
    // Unscaled, strobe 3 would drop rail 0 about 14 ms into power-down.
    cyc(2000);
    `CHK("scaled_hold", 1'b1, rail_enable_register[0])
    cyc(1000);
    `CHK("scaled_off", 1'b0, rail_enable_register[0])
    wait_sg(3'h7, 1'b1, 11000);
    wait_sg(3'h3, 1'b0, 600);
    rail_below_threshold <= 5'h01;
    cyc(20);
    `CHK("uv_deglitch", 4'h6, {power_state, rails_good_output_oe})
    cyc(2);
    `CHK("uv_down", 4'h5, {power_state, rails_good_output_oe})
    print_verdict();
  end
endmodule
